// ### hw/mrm_regbank.sv
// Top of the result register bank with the byte register port.
//
// Contract
// (RQ1) ID readable only with power bit set
// (RQ2) Read-only identity register at 0x40
// (RQ3) 0x41 reserved, no function
// (RQ4) X bits 4..0 in 0x42 bits 7..3
// (RQ5) X bits 12..5 in 0x43
// (RQ6) 0x42 bits 2 and 1 read zero
// (RQ7) 0x42 bit 0 x self-test, resets one
// (RQ8) Y bits 4..0 in 0x44, zeros
// (RQ9) 0x44 bit 0 y self-test, resets one
// (RQ10) Y bits 12..5 in 0x45
// (RQ11) Z fifteen bits over 0x46 and 0x47
// (RQ12) Hall fourteen bits, ready flag, 0x48/49
// (RQ13) XY repetitions register resets to zero
// (RQ14) Z repetitions register at 0x52
// (RQ15) Interrupt source flags held in 0x4A
// (RQ16) Soft reset needs both trigger bits
// (RQ17) Power bit selects suspend or sleep
// (RQ18) Writes to read-only registers ignored
// (RQ19) Host joins bytes as signed values
`timescale 1ns/100ps
module mrm_regbank #(
  parameter logic [7:0] IDENT_VALUE = 8'h5A // Arbitrary identity value.
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  input  wire logic                     smp_valid,
  input  wire logic [mrm_pkg::XY_W-1:0] smp_x,
  input  wire logic [mrm_pkg::XY_W-1:0] smp_y,
  input  wire logic [mrm_pkg::Z_W-1:0]  smp_z,
  input  wire logic [mrm_pkg::H_W-1:0]  smp_h,
  input  wire logic [2:0]               smp_st,
  input  wire logic [7:0]               int_evt,
  output logic                          sleep_mode,
  output logic                          three_wire_select,
  output logic      [7:0]               op_ctl,
  output logic      [7:0]               pin_cfg,
  output logic      [7:0]               thresh,
  output logic      [7:0]               xy_repetitions,
  output logic      [7:0]               z_repetitions
);
  // ************************************************************
  // Power mode and soft reset
  // ************************************************************
  mrm_pkg::mrm_pmode_t pm_r, pm_nxt;
  logic [7:0] pwr_r, pwr_nxt;
  logic [7:0] opc_r, opc_nxt, ien_r, ien_nxt, pin_r, pin_nxt;
  logic [7:0] thr_r, thr_nxt, rxy_r, rxy_nxt, rz_r, rz_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       wr_pwr, soft_clr, flags_rd;
  logic [7:0] flags;
  mrm_res_if  res ();

  assign wr_pwr = reg_wr && (reg_addr == mrm_pkg::OFS_PWR);

  always_comb begin
    pwr_nxt = pwr_r;
    pm_nxt  = pm_r;
    unique case (pm_r)
      mrm_pkg::MRM_SUSPEND: begin
        // (RQ17) Leave suspend on power bit.
        if (wr_pwr && reg_wdata[mrm_pkg::PWR_BIT]) begin
          pm_nxt = mrm_pkg::MRM_SLEEP;
        end
      end
      mrm_pkg::MRM_SLEEP: begin
        // (RQ16) Both trigger bits needed.
        if (wr_pwr && !reg_wdata[mrm_pkg::PWR_BIT]) begin
          pm_nxt = mrm_pkg::MRM_SUSPEND;
        end else if (wr_pwr && reg_wdata[mrm_pkg::SRST_HI_BIT]
                     && reg_wdata[mrm_pkg::SRST_LO_BIT]) begin
          pm_nxt = mrm_pkg::MRM_SRESET;
        end
      end
      mrm_pkg::MRM_SRESET: begin
        // Soft reset always lands in sleep mode.
        pm_nxt = mrm_pkg::MRM_SLEEP;
      end
      default: begin
        pm_nxt = mrm_pkg::MRM_SUSPEND;
      end
    endcase
    if (wr_pwr) begin
      pwr_nxt = reg_wdata & mrm_pkg::PWR_WMASK;
    end
    // (RQ16) Trigger bits self-clear.
    if (pm_r == mrm_pkg::MRM_SRESET) begin
      pwr_nxt[mrm_pkg::SRST_HI_BIT] = 1'b0;
      pwr_nxt[mrm_pkg::SRST_LO_BIT] = 1'b0;
    end
    // Suspend ignores soft reset, so the triggers never stick there.
    if (pm_r == mrm_pkg::MRM_SUSPEND || pm_nxt == mrm_pkg::MRM_SUSPEND) begin
      pwr_nxt[mrm_pkg::SRST_HI_BIT] = 1'b0;
      pwr_nxt[mrm_pkg::SRST_LO_BIT] = 1'b0;
    end
  end

  // Suspend and soft reset clear every register but the power one.
  assign soft_clr = (pm_r != mrm_pkg::MRM_SLEEP);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pm_r  <= mrm_pkg::MRM_SUSPEND;
      pwr_r <= mrm_pkg::RST_PWR;
    end else begin
      pm_r  <= pm_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  always_comb begin
    opc_nxt = opc_r;
    ien_nxt = ien_r;
    pin_nxt = pin_r;
    thr_nxt = thr_r;
    rxy_nxt = rxy_r;
    rz_nxt  = rz_r;
    if (reg_wr && !soft_clr) begin
      unique case (reg_addr)
        mrm_pkg::OFS_OPCTL:  opc_nxt = reg_wdata;
        mrm_pkg::OFS_INTEN:  ien_nxt = reg_wdata;
        mrm_pkg::OFS_PINCFG: pin_nxt = reg_wdata;
        mrm_pkg::OFS_THRESH: thr_nxt = reg_wdata;
        // (RQ13) XY repetition write.
        mrm_pkg::OFS_XYREP:  rxy_nxt = reg_wdata;
        // (RQ14) Z repetition write.
        mrm_pkg::OFS_ZREP:   rz_nxt  = reg_wdata;
        // (RQ18) Read-only writes dropped.
        default: begin
        end
      endcase
    end
    if (soft_clr) begin
      opc_nxt = mrm_pkg::RST_OPCTL;
      ien_nxt = mrm_pkg::RST_INTEN;
      pin_nxt = mrm_pkg::RST_PINCFG;
      thr_nxt = mrm_pkg::RST_ZERO;
      rxy_nxt = mrm_pkg::RST_ZERO;
      rz_nxt  = mrm_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opc_r <= mrm_pkg::RST_OPCTL;
      ien_r <= mrm_pkg::RST_INTEN;
      pin_r <= mrm_pkg::RST_PINCFG;
      thr_r <= mrm_pkg::RST_ZERO;
      rxy_r <= mrm_pkg::RST_ZERO;
      rz_r  <= mrm_pkg::RST_ZERO;
    end else begin
      opc_r <= opc_nxt;
      ien_r <= ien_nxt;
      pin_r <= pin_nxt;
      thr_r <= thr_nxt;
      rxy_r <= rxy_nxt;
      rz_r  <= rz_nxt;
    end
  end

  // ************************************************************
  // Results and flags
  // ************************************************************
  mrm_capture u_capture (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clr       (soft_clr),
    .smp_valid (smp_valid && (pm_r == mrm_pkg::MRM_SLEEP)),
    .smp_x     (smp_x),
    .smp_y     (smp_y),
    .smp_z     (smp_z),
    .smp_h     (smp_h),
    .smp_st    (smp_st),
    .ready_clr (reg_rd && (reg_addr == mrm_pkg::OFS_HLO)),
    .res       (res)
  );

  assign flags_rd = reg_rd && (reg_addr == mrm_pkg::OFS_IFLAGS);

  // (RQ15) Per-source status flags.
  mrm_flags u_flags (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clr     (soft_clr),
    .evt     (int_evt),
    .enables (ien_r),
    .rd_clr  (flags_rd),
    .flags   (flags)
  );

  // ************************************************************
  // Read decode
  // ************************************************************
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      unique case (reg_addr)
        // (RQ1) ID gated by power bit.
        // (RQ2) Fixed identity value.
        mrm_pkg::OFS_IDENT: rdata_nxt = pwr_r[mrm_pkg::PWR_BIT] ?
                                        IDENT_VALUE : mrm_pkg::RST_ZERO;
        // (RQ4) X low bits packed.
        // (RQ6) Fixed zero bits.
        // (RQ7) X self-test flag.
        mrm_pkg::OFS_XLO: rdata_nxt = {res.x_val[4:0], 2'b00,
                                       res.st_flags[0]};
        // (RQ5) X high bits.
        mrm_pkg::OFS_XHI: rdata_nxt = res.x_val[12:5];
        // (RQ8) Y low bits packed.
        // (RQ9) Y self-test flag.
        mrm_pkg::OFS_YLO: rdata_nxt = {res.y_val[4:0], 2'b00,
                                       res.st_flags[1]};
        // (RQ10) Y high bits.
        mrm_pkg::OFS_YHI: rdata_nxt = res.y_val[12:5];
        // (RQ11) Z split over two bytes.
        mrm_pkg::OFS_ZLO: rdata_nxt = {res.z_val[6:0], res.st_flags[2]};
        mrm_pkg::OFS_ZHI: rdata_nxt = res.z_val[14:7];
        // (RQ12) Hall with ready flag.
        mrm_pkg::OFS_HLO: rdata_nxt = {res.h_val[5:0], 1'b0, res.ready};
        mrm_pkg::OFS_HHI: rdata_nxt = res.h_val[13:6];
        mrm_pkg::OFS_IFLAGS: rdata_nxt = flags;
        mrm_pkg::OFS_PWR:    rdata_nxt = pwr_r;
        mrm_pkg::OFS_OPCTL:  rdata_nxt = opc_r;
        mrm_pkg::OFS_INTEN:  rdata_nxt = ien_r;
        mrm_pkg::OFS_PINCFG: rdata_nxt = pin_r;
        mrm_pkg::OFS_THRESH: rdata_nxt = thr_r;
        mrm_pkg::OFS_XYREP:  rdata_nxt = rxy_r;
        mrm_pkg::OFS_ZREP:   rdata_nxt = rz_r;
        // (RQ3) Reserved reads zero.
        default: rdata_nxt = mrm_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_r <= mrm_pkg::RST_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata         = rdata_r;
  assign sleep_mode        = (pm_r == mrm_pkg::MRM_SLEEP);
  assign three_wire_select = pwr_r[mrm_pkg::WIRE3_BIT];
  assign op_ctl            = opc_r;
  assign pin_cfg           = pin_r;
  assign thresh            = thr_r;
  assign xy_repetitions    = rxy_r;
  assign z_repetitions     = rz_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ident_gated: assert property ( // RQ1
    reg_rd && reg_addr == mrm_pkg::OFS_IDENT && !pwr_r[mrm_pkg::PWR_BIT]
    |=> reg_rdata == 8'h00) else $error("identity read while powered off");
  a_ident_value: assert property ( // RQ2
    reg_rd && reg_addr == mrm_pkg::OFS_IDENT && pwr_r[mrm_pkg::PWR_BIT]
    |=> reg_rdata == IDENT_VALUE) else $error("identity value wrong");
  a_rsvd_zero: assert property ( // RQ3
    reg_rd && reg_addr == mrm_pkg::OFS_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved slot not zero");
  a_xlo_pack: assert property ( // RQ4
    reg_rd && reg_addr == mrm_pkg::OFS_XLO
    |=> reg_rdata[7:3] == $past(res.x_val[4:0]))
    else $error("x low bits misplaced");
  a_xhi_pack: assert property ( // RQ5
    reg_rd && reg_addr == mrm_pkg::OFS_XHI
    |=> reg_rdata == $past(res.x_val[12:5]))
    else $error("x high bits misplaced");
  a_xlo_zeros: assert property ( // RQ6
    reg_rd && reg_addr == mrm_pkg::OFS_XLO |=> reg_rdata[2:1] == 2'b00)
    else $error("x low fixed bits not zero");
  a_st_reset: assert property ( // RQ7
    $fell(sys_rst) |-> res.st_flags == 3'h7)
    else $error("self-test flags not one after reset");
  a_ylo_pack: assert property ( // RQ8
    reg_rd && reg_addr == mrm_pkg::OFS_YLO
    |=> reg_rdata == {$past(res.y_val[4:0]), 2'b00, $past(res.st_flags[1])})
    else $error("y low byte misplaced");
  a_zlo_pack: assert property ( // RQ11
    reg_rd && reg_addr == mrm_pkg::OFS_ZLO
    |=> reg_rdata[7:1] == $past(res.z_val[6:0]))
    else $error("z low bits misplaced");
  a_hlo_pack: assert property ( // RQ12
    reg_rd && reg_addr == mrm_pkg::OFS_HLO
    |=> reg_rdata[1:0] == {1'b0, $past(res.ready)})
    else $error("hall low byte flags wrong");
  a_srst_clear: assert property ( // RQ16
    pm_r == mrm_pkg::MRM_SRESET |=> pwr_r[7] == 1'b0 && pwr_r[1] == 1'b0
    && sleep_mode) else $error("soft reset did not finish");
  a_pwr_suspend: assert property ( // RQ17
    wr_pwr && !reg_wdata[0] |=> !sleep_mode)
    else $error("power bit clear did not suspend");
  a_rep_hold: assert property ( // RQ13
    sleep_mode && !(reg_wr && reg_addr == mrm_pkg::OFS_XYREP)
    && pm_nxt == mrm_pkg::MRM_SLEEP |=> $stable(xy_repetitions))
    else $error("xy repetitions changed unwritten");

  c_soft_reset: cover property (pm_r == mrm_pkg::MRM_SRESET);
  c_ident_read: cover property (reg_rd && reg_addr == mrm_pkg::OFS_IDENT
                                && pwr_r[0]);
  c_sample: cover property (smp_valid && sleep_mode);
endmodule : mrm_regbank

// ### inc/mrm_pkg.sv
// Package with register map constants and types of the result register bank.
package mrm_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_IDENT   = 8'h40;
  localparam logic [7:0] OFS_RSVD    = 8'h41;
  localparam logic [7:0] OFS_XLO     = 8'h42;
  localparam logic [7:0] OFS_XHI     = 8'h43;
  localparam logic [7:0] OFS_YLO     = 8'h44;
  localparam logic [7:0] OFS_YHI     = 8'h45;
  localparam logic [7:0] OFS_ZLO     = 8'h46;
  localparam logic [7:0] OFS_ZHI     = 8'h47;
  localparam logic [7:0] OFS_HLO     = 8'h48;
  localparam logic [7:0] OFS_HHI     = 8'h49;
  localparam logic [7:0] OFS_IFLAGS  = 8'h4A;
  localparam logic [7:0] OFS_PWR     = 8'h4B;
  localparam logic [7:0] OFS_OPCTL   = 8'h4C;
  localparam logic [7:0] OFS_INTEN   = 8'h4D;
  localparam logic [7:0] OFS_PINCFG  = 8'h4E;
  localparam logic [7:0] OFS_THRESH  = 8'h4F;
  localparam logic [7:0] OFS_XYREP   = 8'h51;
  localparam logic [7:0] OFS_ZREP    = 8'h52;
  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_PWR     = 8'h01;
  localparam logic [7:0] RST_OPCTL   = 8'h06;
  localparam logic [7:0] RST_INTEN   = 8'h3F;
  localparam logic [7:0] RST_PINCFG  = 8'h07;
  localparam int         PWR_BIT     = 0;
  localparam int         SRST_LO_BIT = 1;
  localparam int         WIRE3_BIT   = 2;
  localparam int         SRST_HI_BIT = 7;
  localparam logic [7:0] PWR_WMASK   = 8'h87;
  localparam int         XY_W        = 13;
  localparam int         Z_W         = 15;
  localparam int         H_W         = 14;
  typedef enum logic [1:0] {
    MRM_SUSPEND = 2'b00,
    MRM_SLEEP   = 2'b01,
    MRM_SRESET  = 2'b10
  } mrm_pmode_t;
endpackage : mrm_pkg

// ### inc/mrm_res_if.sv
// Interface carrying one sample of results between the capture and top.
`timescale 1ns/100ps
interface mrm_res_if;
  logic [mrm_pkg::XY_W-1:0] x_val;
  logic [mrm_pkg::XY_W-1:0] y_val;
  logic [mrm_pkg::Z_W-1:0]  z_val;
  logic [mrm_pkg::H_W-1:0]  h_val;
  logic [2:0]               st_flags;
  logic                     ready;
  modport src (output x_val, y_val, z_val, h_val, st_flags, ready);
  modport dst (input  x_val, y_val, z_val, h_val, st_flags, ready);
endinterface : mrm_res_if

// ### hw/mrm_capture.sv
// Result capture stage holding the latest sample and the ready flag.
`timescale 1ns/100ps
module mrm_capture (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clr,
  input  wire logic                     smp_valid,
  input  wire logic [mrm_pkg::XY_W-1:0] smp_x,
  input  wire logic [mrm_pkg::XY_W-1:0] smp_y,
  input  wire logic [mrm_pkg::Z_W-1:0]  smp_z,
  input  wire logic [mrm_pkg::H_W-1:0]  smp_h,
  input  wire logic [2:0]               smp_st,
  input  wire logic                     ready_clr,
  mrm_res_if.src                        res
);
  logic [mrm_pkg::XY_W-1:0] x_r, x_nxt, y_r, y_nxt;
  logic [mrm_pkg::Z_W-1:0]  z_r, z_nxt;
  logic [mrm_pkg::H_W-1:0]  h_r, h_nxt;
  logic [2:0]               st_r, st_nxt;
  logic                     rdy_r, rdy_nxt;

  always_comb begin
    x_nxt   = x_r;
    y_nxt   = y_r;
    z_nxt   = z_r;
    h_nxt   = h_r;
    st_nxt  = st_r;
    rdy_nxt = rdy_r;
    // A new sample wins over a host clear in the same cycle.
    if (ready_clr) begin
      rdy_nxt = 1'b0;
    end
    if (smp_valid) begin
      x_nxt   = smp_x;
      y_nxt   = smp_y;
      z_nxt   = smp_z;
      h_nxt   = smp_h;
      st_nxt  = smp_st;
      rdy_nxt = 1'b1;
    end
    if (clr) begin
      x_nxt   = '0;
      y_nxt   = '0;
      z_nxt   = '0;
      h_nxt   = '0;
      st_nxt  = 3'h7;
      rdy_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      x_r   <= '0;
      y_r   <= '0;
      z_r   <= '0;
      h_r   <= '0;
      st_r  <= 3'h7;
      rdy_r <= 1'b0;
    end else begin
      x_r   <= x_nxt;
      y_r   <= y_nxt;
      z_r   <= z_nxt;
      h_r   <= h_nxt;
      st_r  <= st_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign res.x_val    = x_r;
  assign res.y_val    = y_r;
  assign res.z_val    = z_r;
  assign res.h_val    = h_r;
  assign res.st_flags = st_r;
  assign res.ready    = rdy_r;
endmodule : mrm_capture

// ### hw/mrm_flags.sv
// Sticky interrupt source flags, set by events and cleared on read.
`timescale 1ns/100ps
module mrm_flags (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clr,
  input  wire logic [7:0] evt,
  input  wire logic [7:0] enables,
  input  wire logic       rd_clr,
  output logic      [7:0] flags
);
  logic [7:0] flags_r, flags_nxt;

  always_comb begin
    flags_nxt = flags_r;
    if (rd_clr) begin
      flags_nxt = mrm_pkg::RST_ZERO;
    end
    // Set beats the read clear so no event is lost.
    flags_nxt = flags_nxt | (evt & enables);
    if (clr) begin
      flags_nxt = mrm_pkg::RST_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_r <= mrm_pkg::RST_ZERO;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule : mrm_flags

// ### bench/mrm_host.sv
// Host processor model driving the byte register port of the bank.
`timescale 1ns/100ps
module mrm_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released address and data are inverted so stale values never match.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    d        = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  function automatic logic [15:0] join16(input logic [7:0] lo,
                                         input logic [7:0] hi,
                                         input int         w);
    return 16'($signed({hi, lo}) >>> (16 - w));
  endfunction : join16
endmodule : mrm_host

// ### bench/tb.sv
// Self-checking bench of the result register bank.
`timescale 1ns/100ps
module tb;
  localparam logic [7:0] ID = 8'hA7; // Arbitrary identity value.
  logic                     sys_clk   = 1'b0;
  logic                     sys_rst   = 1'b1;
  logic                     smp_valid = 1'b0;
  logic [mrm_pkg::XY_W-1:0] smp_x     = '0;
  logic [mrm_pkg::XY_W-1:0] smp_y     = '0;
  logic [mrm_pkg::Z_W-1:0]  smp_z     = '0;
  logic [mrm_pkg::H_W-1:0]  smp_h     = '0;
  logic [2:0]               smp_st    = 3'h0;
  logic [7:0]               int_evt   = 8'h00;
  wire logic                reg_wr;
  wire logic                reg_rd;
  wire logic [7:0]          reg_addr;
  wire logic [7:0]          reg_wdata;
  logic [7:0]               reg_rdata;
  logic                     sleep_mode;
  logic                     three_wire_select;
  logic [7:0]               op_ctl;
  logic [7:0]               pin_cfg;
  logic [7:0]               thresh;
  logic [7:0]               xy_repetitions;
  logic [7:0]               z_repetitions;
  integer                   seed        = 32'hFFFA146B;
  int                       errors      = 0;
  int                       checks_done = 0;
  int                       m [0:255];
  int                       slp;
  logic [7:0]               lo;
  logic [7:0]               hi;

  always #2.5 sys_clk = ~sys_clk;

  mrm_regbank #(.IDENT_VALUE(ID)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z),
    .smp_h(smp_h), .smp_st(smp_st), .int_evt(int_evt),
    .sleep_mode(sleep_mode), .three_wire_select(three_wire_select),
    .op_ctl(op_ctl), .pin_cfg(pin_cfg), .thresh(thresh),
    .xy_repetitions(xy_repetitions), .z_repetitions(z_repetitions));

  mrm_host host (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ************************************************************
  // Reference model
  // ************************************************************
  task automatic mrst();
    m[8'h4A] = 0;
    m[8'h4C] = 8'h06;
    m[8'h4D] = 8'h3F;
    m[8'h4E] = 8'h07;
    m[8'h4F] = 0;
    m[8'h51] = 0;
    m[8'h52] = 0;
    // Results clear too; the three self-test flags come back as one.
    for (int a = 8'h42; a <= 8'h49; a++) begin
      m[a] = (a <= 8'h46 && a % 2 == 0) ? 1 : 0;
    end
  endtask : mrst

  task automatic mwr(input int a, input int d);
    int v;
    v = d & 8'h87;
    if (a == 8'h4B) begin
      if (slp == 0) begin
        v &= 8'h05;
      end else if ((v & 8'h82) == 8'h82) begin
        mrst();
        v &= 8'h05;
      end
      m[8'h4B] = v;
      slp = v & 1;
      if (slp == 0) mrst();
    end else if (slp != 0 && a >= 8'h4C && a <= 8'h52 && a != 8'h50) begin
      m[a] = d;
    end
  endtask : mwr

  // Reading the ready byte or the flag byte clears what it reported.
  function automatic logic [7:0] mrd(input int a);
    mrd = m[a][7:0];
    if (a == 8'h40) mrd = ((m[8'h4B] & 1) != 0) ? ID : 8'h00;
    if (a == 8'h48) m[8'h48] &= 8'hFE;
    if (a == 8'h4A) m[8'h4A] = 0;
  endfunction : mrd

  // ************************************************************
  // Checking and stimulus
  // ************************************************************
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    mwr(a, d);
  endtask : w

  task automatic rc(input logic [7:0] a);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, mrd(a)}, {8'h00, d});
  endtask : rc

  task automatic outs();
    chk("sleep_mode", 16'(slp), {15'h0, sleep_mode});
    chk("three_wire", 16'(m[8'h4B] >> 2 & 1), {15'h0, three_wire_select});
    chk("op_ctl", 16'(m[8'h4C]), {8'h00, op_ctl});
    chk("pin_cfg", 16'(m[8'h4E]), {8'h00, pin_cfg});
    chk("thresh", 16'(m[8'h4F]), {8'h00, thresh});
    chk("xy_rep", 16'(m[8'h51]), {8'h00, xy_repetitions});
    chk("z_rep", 16'(m[8'h52]), {8'h00, z_repetitions});
  endtask : outs

  task automatic samp();
    @(posedge sys_clk);
    #1;
    smp_x     = 13'($random(seed));
    smp_y     = 13'($random(seed));
    smp_z     = 15'($random(seed));
    smp_h     = 14'($random(seed));
    smp_st    = 3'($random(seed));
    smp_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    smp_valid = 1'b0;
    m[8'h42]  = {smp_x[4:0], 2'b00, smp_st[0]};
    m[8'h43]  = smp_x[12:5];
    m[8'h44]  = {smp_y[4:0], 2'b00, smp_st[1]};
    m[8'h45]  = smp_y[12:5];
    m[8'h46]  = {smp_z[6:0], smp_st[2]};
    m[8'h47]  = smp_z[14:7];
    m[8'h48]  = {smp_h[5:0], 2'b01};
    m[8'h49]  = smp_h[13:6];
  endtask : samp

  task automatic evt();
    @(posedge sys_clk);
    #1;
    int_evt = 8'($random(seed));
    @(posedge sys_clk);
    #1;
    m[8'h4A] |= int_evt & m[8'h4D];
    int_evt = 8'h00;
  endtask : evt

  task automatic end_sim();
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    foreach (m[i]) m[i] = 0;
    m[8'h4B] = 1;
    slp      = 0;
    mrst();
    repeat (8) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    outs();
    for (int a = 8'h41; a <= 8'h53; a++) rc(8'(a));
    w(8'h4B, 8'h00);
    rc(8'h40);
    w(8'h4B, 8'h01);
    w(8'h40, 8'($random(seed)));
    rc(8'h40);
    foreach (m[a]) begin
      if (a >= 8'h4C && a <= 8'h52) w(8'(a), 8'($random(seed)));
    end
    w(8'h41, 8'($random(seed)));
    for (int a = 8'h41; a <= 8'h53; a++) rc(8'(a));
    outs();
    for (int k = 0; k < 4; k++) begin
      samp();
      w(8'h42 + 8'(k), 8'($random(seed)));
      for (int a = 8'h42; a <= 8'h49; a++) rc(8'(a));
      rc(8'h48);
      host.rd(8'h42, lo);
      host.rd(8'h43, hi);
      chk("x joined", 16'($signed(smp_x)), host.join16(lo, hi, 13));
      host.rd(8'h46, lo);
      host.rd(8'h47, hi);
      chk("z joined", 16'($signed(smp_z)), host.join16(lo, hi, 15));
    end
    for (int k = 0; k < 4; k++) begin
      evt();
      evt();
      rc(8'h4A);
      rc(8'h4A);
    end
    w(8'h4B, 8'h81);
    rc(8'h4B);
    w(8'h4C, 8'hA5);
    w(8'h4B, 8'h83);
    for (int a = 8'h42; a <= 8'h52; a++) rc(8'(a));
    outs();
    w(8'h4B, 8'h05);
    rc(8'h4B);
    outs();
    w(8'h4B, 8'h00);
    w(8'h51, 8'hAA);
    rc(8'h51);
    w(8'h4B, 8'h82);
    rc(8'h4B);
    outs();
    // Waking with the trigger bits set must drop them, not keep them.
    w(8'h4B, 8'h83);
    rc(8'h4B);
    outs();
    end_sim();
  end
endmodule : tb
